// file: src/cfx_pkg.sv
// Shared constants and types for the fetch, execute and data map core.
package cfx_pkg;

   // ---------------------------------------------------------------
   // Instruction cycle phases
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      phase_one,
      phase_two,
      phase_three,
      phase_four
   } cfx_phase_t;

   // ---------------------------------------------------------------
   // Program memory
   // ---------------------------------------------------------------
   localparam logic [12:0] RESET_VECTOR = 13'h0000;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   localparam logic [13:0] NOP_WORD = 14'h0000;
   localparam int PROG_WORDS_DEFAULT = 2048;

   // ---------------------------------------------------------------
   // Core registers: offsets within each bank, fields, reset values
   // ---------------------------------------------------------------
   localparam logic [6:0] ADDR_INDIRECT = 7'h00;
   localparam logic [6:0] ADDR_PCL = 7'h02;
   localparam logic [6:0] ADDR_FLAGS = 7'h03;
   localparam logic [6:0] ADDR_POINTER = 7'h04;
   localparam logic [6:0] ADDR_PROGRAM_COUNTER_HIGH_LATCH = 7'h0A;
   localparam logic [6:0] ADDR_INTERRUPT_CONTROL = 7'h0B;
   localparam int FLAG_IRP = 7;
   localparam int FLAG_RP1 = 6;
   localparam int FLAG_RP0 = 5;
   localparam int FLAG_Z = 2;
   localparam int FLAG_C = 0;
   localparam int INT_GIE = 7;
   localparam logic [7:0] FLAGS_RESET = 8'h18;
   localparam logic [7:0] FLAGS_RO_MASK = 8'h18;
   localparam logic [7:0] PCL_RESET = 8'h00;
   localparam logic [4:0] PROGRAM_COUNTER_HIGH_LATCH_RESET = 5'h00;
   localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [7:0] ACC_RESET = 8'h00;

   // ---------------------------------------------------------------
   // General purpose RAM layout
   // ---------------------------------------------------------------
   localparam int RAM_BYTES = 224;
   localparam logic [6:0] SFR_SPAN = 7'h20;
   localparam logic [6:0] COMMON_BASE = 7'h70;
   localparam logic [6:0] BANK2_TOP = 7'h50;
   localparam logic [7:0] BANK1_BASE = 8'h60;
   localparam logic [7:0] BANK2_BASE = 8'hB0;

   // ---------------------------------------------------------------
   // Instruction encodings
   // ---------------------------------------------------------------
   localparam logic [5:0] OP_STORE = 6'h00;
   localparam logic [5:0] OP_ADD = 6'h07;
   localparam logic [5:0] OP_MOVE = 6'h08;
   localparam logic [5:0] OP_INC = 6'h0A;
   localparam logic [1:0] CLASS_LITERAL = 2'h3;
   localparam logic [2:0] CLASS_JUMP = 3'h5;

   // ---------------------------------------------------------------
   // Bus map (word indices; byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [9:0] BUS_CTRL_IDX = 10'h200;
   localparam logic [9:0] BUS_STAT_IDX = 10'h201;
   localparam logic CTRL_RUN_RESET = 1'b1;

endpackage : cfx_pkg

// file: src/cfx_core.sv
// Core instruction timing, program counter and banked data memory.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Clock divided by four into four non-overlapping phase strobes.
// RULE_02: Counter advances in phase one; fetched word latched in phase four.
// RULE_03: Next word is fetched while the current one executes.
// RULE_04: Counter-changing instructions take two cycles; fetched word dropped.
// RULE_05: Operand read in phase two, result written in phase four.
// RULE_06: Program counter is 13 bits over an 8K by 14 space.
// RULE_07: Addresses above implemented program memory wrap into it.
// RULE_08: Execution starts at zero after reset; interrupts go to four.
// RULE_09: Two bank bits select one of four data banks.
// RULE_10: Lowest 32 addresses of every bank are special registers.
// RULE_11: Listed ranges are general purpose static RAM.
// RULE_12: Top sixteen bytes of banks 1-3 mirror bank 0 common RAM.
// RULE_13: Register file reachable directly and through the pointer.
// RULE_14: Unimplemented data addresses read as zero.
// RULE_15: Counter loads take upper five bits from the high latch; jumps here take only latch bits 4:3 above 11 instruction bits.
// RULE_16: Data address is bank bits plus seven bits or pointer.
module cfx_core #(
   parameter int PROG_WORDS = cfx_pkg::PROG_WORDS_DEFAULT
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [11:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [12:0] prog_addr_o,
   input wire logic [13:0] prog_data_i,
   input wire logic irq_i,
   output logic [3:0] phase_o,
   output logic [13:0] instruction_latch_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   localparam logic [12:0] PROG_MASK = 13'(PROG_WORDS - 1);

   cfx_pkg::cfx_phase_t phase_q;
   logic [12:0] pc_q;
   logic [12:0] prog_addr_q;
   logic [13:0] ir_q;
   logic flush_q;
   logic [7:0] acc_q;
   logic [7:0] operand_q;
   logic [7:0] flags_q;
   logic [7:0] pointer_q;
   logic [4:0] program_counter_high_latch_q;
   logic [7:0] interrupt_control_q;
   logic [7:0] ram_q [cfx_pkg::RAM_BYTES];
   logic run_q;
   logic ack_q;
   logic [31:0] rdata_q;

   logic ph1, ph2, ph3, ph4;
   logic [5:0] op;
   logic dest_f;
   logic [8:0] core_addr;
   logic is_jump, is_literal, writes_f, updates_flags;
   logic [8:0] alu_sum;
   logic [7:0] result;
   logic irq_take;
   logic bus_req, bus_slot;
   logic [9:0] bus_idx;
   logic [8:0] bus_addr;
   logic bus_wr;
   logic wr_en;
   logic [8:0] wr_addr;
   logic [7:0] wr_data;
   logic [8:0] wr_slot;
   logic core_pcl_wr, bus_pcl_wr;
   logic branch_now;

   // ---------------------------------------------------------------
   // Decoding functions
   // ---------------------------------------------------------------
   // Returns {hit, index} of the RAM cell behind a 9-bit data address.
   function automatic logic [8:0] ram_slot(input logic [8:0] a);
      logic [6:0] off;
      off = a[6:0] - cfx_pkg::SFR_SPAN;
      ram_slot = 9'h000;
      if (a[6:0] < cfx_pkg::SFR_SPAN) begin // RULE_10
         ram_slot = 9'h000;
      end else if (a[6:0] >= cfx_pkg::COMMON_BASE || a[8:7] == 2'h0) begin
         ram_slot = {1'b1, 1'b0, off}; // RULE_12
      end else if (a[8:7] == 2'h1) begin
         ram_slot = {1'b1, 8'({1'b0, off}) + cfx_pkg::BANK1_BASE}; // RULE_11
      end else if (a[8:7] == 2'h2 && a[6:0] < cfx_pkg::BANK2_TOP) begin
         ram_slot = {1'b1, 8'({1'b0, off}) + cfx_pkg::BANK2_BASE}; // RULE_11
      end
   endfunction : ram_slot

   // Offset zero in any bank is replaced by the indirect pointer.
   function automatic logic [8:0] resolve(input logic [8:0] a);
      resolve = a;
      if (a[6:0] == cfx_pkg::ADDR_INDIRECT) begin
         resolve = {flags_q[cfx_pkg::FLAG_IRP], pointer_q}; // RULE_13
      end
   endfunction : resolve

   // Reads a resolved data address; core registers appear in all banks.
   function automatic logic [7:0] rd(input logic [8:0] a);
      logic [8:0] slot;
      slot = ram_slot(a);
      unique case (a[6:0])
         cfx_pkg::ADDR_PCL: rd = pc_q[7:0];
         cfx_pkg::ADDR_FLAGS: rd = flags_q;
         cfx_pkg::ADDR_POINTER: rd = pointer_q;
         cfx_pkg::ADDR_PROGRAM_COUNTER_HIGH_LATCH: rd = {3'h0, program_counter_high_latch_q};
         cfx_pkg::ADDR_INTERRUPT_CONTROL: rd = interrupt_control_q;
         default: rd = slot[8] ? ram_q[slot[7:0]] : 8'h00; // RULE_14
      endcase
   endfunction : rd

   // ---------------------------------------------------------------
   // Phase generation
   // ---------------------------------------------------------------
   assign ph1 = (phase_q == cfx_pkg::phase_one);
   assign ph2 = (phase_q == cfx_pkg::phase_two);
   assign ph3 = (phase_q == cfx_pkg::phase_three);
   assign ph4 = (phase_q == cfx_pkg::phase_four);
   assign phase_o = {ph4, ph3, ph2, ph1};

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         phase_q <= cfx_pkg::phase_one;
      end else begin
         unique case (phase_q) // RULE_01
            cfx_pkg::phase_one: phase_q <= cfx_pkg::phase_two;
            cfx_pkg::phase_two: phase_q <= cfx_pkg::phase_three;
            cfx_pkg::phase_three: phase_q <= cfx_pkg::phase_four;
            cfx_pkg::phase_four: phase_q <= cfx_pkg::phase_one;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Instruction decode and arithmetic
   // ---------------------------------------------------------------
   assign op = ir_q[13:8];
   assign dest_f = ir_q[7];
   always_comb core_addr = resolve({flags_q[cfx_pkg::FLAG_RP1],
                                    flags_q[cfx_pkg::FLAG_RP0],
                                    ir_q[6:0]}); // RULE_09 RULE_16
   assign is_jump = (ir_q[13:11] == cfx_pkg::CLASS_JUMP);
   assign is_literal = (ir_q[13:12] == cfx_pkg::CLASS_LITERAL);
   assign updates_flags = (op == cfx_pkg::OP_MOVE) ||
                          (op == cfx_pkg::OP_ADD) || (op == cfx_pkg::OP_INC);
   assign writes_f = dest_f && (updates_flags || op == cfx_pkg::OP_STORE);
   assign alu_sum = (op == cfx_pkg::OP_ADD) ?
                    {1'b0, acc_q} + {1'b0, operand_q} :
                    {1'b0, operand_q} + 9'h001;

   always_comb begin
      unique case (op)
         cfx_pkg::OP_STORE: result = acc_q;
         cfx_pkg::OP_MOVE: result = operand_q;
         default: result = alu_sum[7:0];
      endcase
   end

   assign irq_take = ph4 && run_q && irq_i && interrupt_control_q[cfx_pkg::INT_GIE];

   // ---------------------------------------------------------------
   // Bus slave; accesses use the free third phase of each cycle
   // ---------------------------------------------------------------
   // Parking the bus on phase three keeps it off the core's read and
   // write phases, at the cost of up to four cycles of wait.
   assign bus_req = avs_read_i || avs_write_i;
   assign bus_slot = ph3 && bus_req && !ack_q;
   assign bus_idx = avs_address_i[11:2];
   always_comb bus_addr = resolve(bus_idx[8:0]);
   assign bus_wr = bus_slot && avs_write_i && !bus_idx[9] &&
                   avs_byteenable_i[0];
   assign avs_waitrequest_o = !ack_q;
   assign avs_readdata_o = rdata_q;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_slot;
         if (bus_slot && avs_read_i) begin
            if (!bus_idx[9]) begin
               rdata_q <= {24'h00_0000, rd(bus_addr)};
            end else if (bus_idx == cfx_pkg::BUS_CTRL_IDX) begin
               rdata_q <= {31'h0000_0000, run_q};
            end else if (bus_idx == cfx_pkg::BUS_STAT_IDX) begin
               rdata_q <= {14'h0000, phase_q, 3'h0, pc_q};
            end else begin
               rdata_q <= 32'h0000_0000;
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         run_q <= cfx_pkg::CTRL_RUN_RESET;
      end else if (bus_slot && avs_write_i && avs_byteenable_i[0] &&
                   bus_idx == cfx_pkg::BUS_CTRL_IDX) begin
         run_q <= avs_writedata_i[0];
      end
   end

   // ---------------------------------------------------------------
   // Shared data memory write port
   // ---------------------------------------------------------------
   always_comb begin
      wr_en = 1'b0;
      wr_addr = core_addr;
      wr_data = result;
      if (ph4 && run_q && writes_f) begin // RULE_05
         wr_en = 1'b1;
      end else if (bus_wr) begin
         wr_en = 1'b1;
         wr_addr = bus_addr;
         wr_data = avs_writedata_i[7:0];
      end
   end

   assign wr_slot = ram_slot(wr_addr);
   assign core_pcl_wr = wr_en && ph4 && wr_addr[6:0] == cfx_pkg::ADDR_PCL;
   assign bus_pcl_wr = wr_en && ph3 && wr_addr[6:0] == cfx_pkg::ADDR_PCL;
   assign branch_now = ph4 && run_q && (is_jump || core_pcl_wr || irq_take);

   always_ff @(posedge clock_i) begin
      if (wr_en && wr_slot[8]) begin
         ram_q[wr_slot[7:0]] <= wr_data; // RULE_11
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         pointer_q <= cfx_pkg::POINTER_RESET;
      end else if (wr_en && wr_addr[6:0] == cfx_pkg::ADDR_POINTER) begin
         pointer_q <= wr_data;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         program_counter_high_latch_q <= cfx_pkg::PROGRAM_COUNTER_HIGH_LATCH_RESET;
      end else if (wr_en && wr_addr[6:0] == cfx_pkg::ADDR_PROGRAM_COUNTER_HIGH_LATCH) begin
         program_counter_high_latch_q <= wr_data[4:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         interrupt_control_q <= cfx_pkg::INTERRUPT_CONTROL_RESET;
      end else if (wr_en && wr_addr[6:0] == cfx_pkg::ADDR_INTERRUPT_CONTROL) begin
         interrupt_control_q <= wr_data;
      end else if (irq_take) begin
         interrupt_control_q[cfx_pkg::INT_GIE] <= 1'b0;
      end
   end

   // Power-down style bits are read only; software cannot disturb them.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         flags_q <= cfx_pkg::FLAGS_RESET;
      end else if (wr_en && wr_addr[6:0] == cfx_pkg::ADDR_FLAGS) begin
         flags_q <= (wr_data & ~cfx_pkg::FLAGS_RO_MASK) |
                    (flags_q & cfx_pkg::FLAGS_RO_MASK);
      end else if (ph4 && run_q && updates_flags) begin
         flags_q[cfx_pkg::FLAG_Z] <= (result == 8'h00);
         if (op == cfx_pkg::OP_ADD) begin
            flags_q[cfx_pkg::FLAG_C] <= alu_sum[8];
         end
      end
   end

   // ---------------------------------------------------------------
   // Execute: operand read and accumulator
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         operand_q <= 8'h00;
      end else if (ph2 && run_q) begin
         operand_q <= rd(core_addr); // RULE_05 RULE_13
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         acc_q <= cfx_pkg::ACC_RESET;
      end else if (ph4 && run_q) begin
         if (is_literal) begin
            acc_q <= ir_q[7:0];
         end else if (updates_flags && !dest_f) begin
            acc_q <= result;
         end
      end
   end

   // ---------------------------------------------------------------
   // Fetch: program counter and instruction latch
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         pc_q <= cfx_pkg::RESET_VECTOR; // RULE_08
         prog_addr_q <= cfx_pkg::RESET_VECTOR;
      end else if (ph1 && run_q) begin
         prog_addr_q <= pc_q & PROG_MASK; // RULE_07
         pc_q <= pc_q + 13'h0001; // RULE_02 RULE_06
      end else if (irq_take) begin
         pc_q <= cfx_pkg::IRQ_VECTOR; // RULE_08
      end else if (ph4 && run_q && is_jump) begin
         pc_q <= {program_counter_high_latch_q[4:3], ir_q[10:0]}; // RULE_15
      end else if (core_pcl_wr || bus_pcl_wr) begin
         pc_q <= {program_counter_high_latch_q, wr_data}; // RULE_15
      end
   end

   // A bus write to the counter low byte lands in phase three, after
   // this cycle's fetch address went out, so that word is dropped too.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         flush_q <= 1'b0;
      end else if (bus_pcl_wr) begin
         flush_q <= 1'b1;
      end else if (ph4) begin
         flush_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ir_q <= cfx_pkg::NOP_WORD;
      end else if (ph4 && run_q) begin
         if (branch_now || flush_q) begin
            ir_q <= cfx_pkg::NOP_WORD; // RULE_04
         end else begin
            ir_q <= prog_data_i; // RULE_02 RULE_03
         end
      end
   end

   assign prog_addr_o = prog_addr_q;
   assign instruction_latch_o = ir_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   logic [6:0] wr_off;
   assign wr_off = wr_addr[6:0];

   phase_rotate_a: assert property (ph1 |=> ph2 ##1 ph3 ##1 ph4 ##1 ph1) // RULE_01
      else $error("phase strobes out of order");
   pc_advance_a: assert property (ph1 && run_q |=> // RULE_02
      pc_q == $past(pc_q) + 13'h0001 && prog_addr_o == ($past(pc_q) & PROG_MASK))
      else $error("counter did not advance in phase one");
   ir_capture_a: assert property ( // RULE_03
      ph4 && run_q && !branch_now && !flush_q |=>
      instruction_latch_o == $past(prog_data_i))
      else $error("fetched word not latched in phase four");
   jump_flush_a: assert property ( // RULE_04
      ph4 && run_q && is_jump && !irq_i |=>
      ir_q == cfx_pkg::NOP_WORD && pc_q == {$past(program_counter_high_latch_q[4:3]),
                                           $past(ir_q[10:0])})
      else $error("jump did not flush or load target");
   write_phase_a: assert property (wr_en |-> ph4 || ph3) // RULE_05
      else $error("data write outside its phases");
   prog_wrap_a: assert property (prog_addr_o <= PROG_MASK) // RULE_07
      else $error("program address beyond implemented memory");
   reset_vector_a: assert property ($fell(srst_i) |=> // RULE_08
      prog_addr_q == cfx_pkg::RESET_VECTOR &&
      pc_q == cfx_pkg::RESET_VECTOR + 13'h0001)
      else $error("execution did not start at zero");
   irq_vector_a: assert property (irq_take |=> // RULE_08
      pc_q == cfx_pkg::IRQ_VECTOR && !interrupt_control_q[cfx_pkg::INT_GIE])
      else $error("interrupt did not vector to four");
   common_mirror_a: assert property ( // RULE_12
      wr_en && wr_off >= cfx_pkg::COMMON_BASE |=>
      rd({2'h0, $past(wr_off)}) == $past(wr_data))
      else $error("common RAM not mirrored");
   unimpl_zero_a: assert property ( // RULE_14
      bus_slot && avs_read_i && !bus_idx[9] && ram_slot(bus_addr) < 9'h100 &&
      bus_addr[6:0] >= cfx_pkg::SFR_SPAN |=> avs_readdata_o == 32'h0000_0000)
      else $error("unimplemented address read nonzero");

   jump_seen_c: cover property (ph4 && run_q && is_jump);
   irq_seen_c: cover property (irq_take);
   bus_write_c: cover property (bus_wr ##1 !avs_waitrequest_o);
   indirect_c: cover property (ph2 && run_q && ir_q[6:0] == 7'h00);

endmodule : cfx_core

// file: tb/cfx_prog_mem.sv
// Program memory model that answers the core's fetch address.
`timescale 1ns/1ps
module cfx_prog_mem #(
   parameter int PROG_WORDS = 1024
) (
   input wire logic [12:0] prog_addr_i,
   output logic [13:0] prog_data_o
);
   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [13:0] words [PROG_WORDS];
   // Only implemented words exist, so the index wraps into them.
   assign prog_data_o = words[prog_addr_i % PROG_WORDS];
endmodule : cfx_prog_mem

// file: tb/testbench.sv
// Self-checking bench for the fetch, execute and data map core.
`timescale 1ns/1ps
module testbench;
   localparam int WORDS = 1024;
   logic clock_i;
   logic srst_i;
   logic [11:0] avs_address_i;
   logic avs_read_i;
   logic avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0] avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [12:0] prog_addr_o;
   logic [13:0] prog_data_i;
   logic irq_i;
   logic [3:0] phase_o;
   logic [13:0] instruction_latch_o;
   int err_total = 0;
   int checks = 0;
   int cycles = 0;

   cfx_core #(.PROG_WORDS(WORDS)) uut (
      .clock_i(clock_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i), .irq_i(irq_i),
      .phase_o(phase_o), .instruction_latch_o(instruction_latch_o));
   cfx_prog_mem #(.PROG_WORDS(WORDS)) mem (
      .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i));

   initial begin
      clock_i = 1'h0;
      forever #5 clock_i = ~clock_i;
   end

   // ---------------------------------------------------------------
   // Reporting
   // ---------------------------------------------------------------
   task automatic final_report;
      if (err_total == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         err_total++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask : check

   // The whole run needs well under a thousand cycles.
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         final_report();
      end
   end

   // ---------------------------------------------------------------
   // Register bus master
   // ---------------------------------------------------------------
   task automatic wait_ack;
      do begin
         @(posedge clock_i);
      end while (avs_waitrequest_o !== 1'h0);
   endtask : wait_ack

   task automatic bus_wr(input logic [9:0] idx, input logic [7:0] d,
         input logic [3:0] be = 4'hF);
      @(posedge clock_i);
      avs_address_i <= {idx, 2'h0};
      avs_writedata_i <= {24'h000000, d};
      avs_byteenable_i <= be;
      avs_write_i <= 1'h1;
      wait_ack();
      avs_write_i <= 1'h0;
   endtask : bus_wr

   task automatic rd_chk(input logic [9:0] idx, input logic [7:0] want);
      @(posedge clock_i);
      avs_address_i <= {idx, 2'h0};
      avs_read_i <= 1'h1;
      wait_ack();
      check(avs_readdata_o, {24'h000000, want});
      avs_read_i <= 1'h0;
   endtask : rd_chk

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_fetch;
      logic [12:0] want [6] = '{13'h0000, 13'h0001, 13'h0002, 13'h0003,
         13'h0006, 13'h0007};
      int n = 0;
      bit armed = 0;
      repeat (3) @(posedge clock_i);
      srst_i <= 1'h0;
      while (n < 6) begin
         @(posedge clock_i);
         if (phase_o === 4'h1) armed = 1;
         if (armed && phase_o === 4'h2) begin
            check(prog_addr_o, want[n]);
            if (n == 5) check(instruction_latch_o, 14'h0AF0);
            n++;
         end
      end
   endtask : t_fetch

   task automatic t_phase;
      do begin
         @(posedge clock_i);
      end while (phase_o !== 4'h1);
      for (int i = 1; i < 9; i++) begin
         @(posedge clock_i);
         check(phase_o, 4'h1 << (i % 4));
      end
   endtask : t_phase

   task automatic t_exec;
      logic [9:0] mir [4] = '{10'h070, 10'h0F0, 10'h170, 10'h1F0};
      // Increment read 0x5A and wrote 0x5B; the flushed literal never ran.
      for (int i = 0; i < 4; i++) rd_chk(mir[i], 8'h5B);
      rd_chk(10'h022, 8'h5A);
   endtask : t_exec

   task automatic t_regs;
      rd_chk(10'h003, cfx_pkg::FLAGS_RESET);
      rd_chk(10'h004, cfx_pkg::POINTER_RESET);
      rd_chk(10'h00A, 8'h00);
      rd_chk(10'h00B, cfx_pkg::INTERRUPT_CONTROL_RESET);
      rd_chk(10'h200, 8'h01);
      rd_chk(10'h001, 8'h00);
      rd_chk(10'h007, 8'h00);
      bus_wr(10'h083, 8'h65);
      rd_chk(10'h103, 8'h65 | cfx_pkg::FLAGS_RO_MASK);
      bus_wr(10'h183, 8'h00);
      rd_chk(10'h003, cfx_pkg::FLAGS_RESET);
      bus_wr(10'h08A, 8'hFF);
      rd_chk(10'h18A, 8'h1F);
   endtask : t_regs

   task automatic t_map;
      logic [9:0] gp [6] = '{10'h020, 10'h06F, 10'h0A0, 10'h0EF, 10'h120,
         10'h14F};
      for (int i = 0; i < 6; i++) bus_wr(gp[i], 8'h30 + 8'(i));
      for (int i = 0; i < 6; i++) rd_chk(gp[i], 8'h30 + 8'(i));
      bus_wr(10'h1F5, 8'h77);
      rd_chk(10'h075, 8'h77);
      rd_chk(10'h175, 8'h77);
      bus_wr(10'h150, 8'hAA);
      rd_chk(10'h150, 8'h00);
      bus_wr(10'h030, 8'h11);
      bus_wr(10'h030, 8'h22, 4'hE);
      rd_chk(10'h030, 8'h11);
      bus_wr(10'h3FF, 8'h55);
      rd_chk(10'h3FF, 8'h00);
   endtask : t_map

   task automatic t_indirect;
      bus_wr(10'h004, 8'h25);
      bus_wr(10'h000, 8'h99);
      rd_chk(10'h025, 8'h99);
      rd_chk(10'h000, 8'h99);
      bus_wr(10'h003, 8'h80);
      bus_wr(10'h000, 8'h44);
      rd_chk(10'h125, 8'h44);
      rd_chk(10'h025, 8'h99);
      bus_wr(10'h003, 8'h00);
   endtask : t_indirect

   task automatic t_counter_load;
      // The high latch holds 0x1F, so the target lies past the array.
      // A jump executing in the same cycle would override the counter, so
      // the write is placed in the cycle after a jump, which runs a nop.
      do begin
         @(posedge clock_i);
      end while (phase_o !== 4'h8 || instruction_latch_o !== 14'h2808);
      bus_wr(10'h002, 8'h02);
      for (int n = 0; n < 2; n++) begin
         do begin
            @(posedge clock_i);
         end while (phase_o !== 4'h2);
         check(prog_addr_o, 13'h0302 + 13'(n));
      end
   endtask : t_counter_load

   task automatic t_irq;
      irq_i <= 1'h1;
      // Masked request: the loop at 0x302 must keep running.
      for (int i = 0; i < 8; i++) begin
         @(posedge clock_i);
         check(prog_addr_o & 13'h1FFE, 13'h0302);
      end
      bus_wr(10'h00B, 8'h80);
      for (int i = 0; i < 12 && prog_addr_o !== 13'h0004; i++) begin
         @(posedge clock_i);
      end
      check(prog_addr_o, cfx_pkg::IRQ_VECTOR);
      irq_i <= 1'h0;
      rd_chk(10'h00B, 8'h00);
   endtask : t_irq

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      srst_i = 1'h1;
      avs_address_i = 12'h000;
      avs_read_i = 1'h0;
      avs_write_i = 1'h0;
      avs_writedata_i = 32'h00000000;
      avs_byteenable_i = 4'hF;
      irq_i = 1'h0;
      for (int i = 0; i < WORDS; i++) mem.words[i] = cfx_pkg::NOP_WORD;
      mem.words[0] = 14'h305A;
      mem.words[1] = 14'h00F0;
      mem.words[2] = 14'h2806;
      mem.words[3] = 14'h30FF;
      mem.words[4] = 14'h2804;
      mem.words[6] = 14'h0AF0;
      mem.words[7] = 14'h00A2;
      mem.words[8] = 14'h2808;
      mem.words[10'h302] = 14'h2B02;
      t_fetch();
      t_phase();
      t_exec();
      t_regs();
      t_map();
      t_indirect();
      t_counter_load();
      t_irq();
      final_report();
   end
endmodule : testbench
